// ### logic/btzm_monitor.sv
// Purpose: Battery temperature zone monitor with APB registers
// Assumes: Sense level arrives as millivolts from an external converter
// Notes:   Notes on behaviour below; outputs all come from flip-flops
//
// Notes on behaviour
// - Enabled monitor evaluates sense level continuously.
// - Normal zone uses normal charge settings.
// - Warm or cool zone uses zone settings.
// - Zone settings independent; equal values accepted.
// - Hot or cold zone pauses charging, fault.
// - Zone status field; change raises maskable interrupt.
// - Disabled monitor takes no temperature action.
// - Four separate 2-bit trip selects.
// - Trip levels from twelve listed voltages.
// - Bias driven when input valid and enabled.
// - Bias driven when monitor selects sense/bias.
// - Monitor channel never affects zone response.
// - Temperature fault outranks others; restores prior state.
// - Charger timers paused during temperature fault.
// - Charger resumes previous state, no restart.
`timescale 1ns/100ps
`default_nettype none
`include "btzm_defs.svh"

module btzm_monitor (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [10:0] ntc_sense_pin,
    input wire logic charge_input_valid,
    // Charger state machine
    input wire logic [3:0] charger_state,
    input wire logic other_fault_req,
    // Charger steering
    output logic [5:0] applied_charge_voltage,
    output logic [5:0] applied_charge_current,
    output logic zone_adjust_active,
    output logic temp_fault_active,
    output logic charger_fault,
    output logic timers_pause,
    output logic resume_strobe,
    output logic [3:0] resume_state,
    // Analog side
    output logic ntc_bias_source,
    output logic [3:0] analog_monitor_out,
    output logic temperature_change_irq
);
    import btzm_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [10:0] sense_meta_reg, sense_sync_reg;
    logic valid_meta_reg, valid_sync_reg;

    // Pin levels cross two flops; the converter holds its word steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_meta_reg <= 11'h000;
            sense_sync_reg <= 11'h000;
            valid_meta_reg <= 1'b0;
            valid_sync_reg <= 1'b0;
        end else if (clk_en) begin
            sense_meta_reg <= ntc_sense_pin;
            sense_sync_reg <= sense_meta_reg;
            valid_meta_reg <= charge_input_valid;
            valid_sync_reg <= valid_meta_reg;
        end
    end

    // ----------------------------------------
    // Register file state
    // ----------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] charge_reg, charge_next;
    logic irq_stat_reg, irq_stat_next;
    logic irq_mask_reg, irq_mask_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next;
    logic access, wr_take, rd_take, addr_hit;
    logic zone_changed;
    btzm_zone_t zone_reg, zone_next;
    btzm_state_t state_reg, state_next;

    // One wait state: pready rises in the second access cycle
    assign access = psel && penable;
    assign wr_take = access && pready && pwrite;
    assign rd_take = access && !pready && !pwrite;

    // Decode used only for the error answer; reads and writes case on paddr directly
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `BTZM_OFF_CTRL) || (a == `BTZM_OFF_CHARGE) ||
               (a == `BTZM_OFF_STATUS) || (a == `BTZM_OFF_IRQ_STAT) ||
               (a == `BTZM_OFF_IRQ_MASK);
    endfunction

    assign addr_hit = is_mapped(paddr);

    // Bus answer and register writes
    always_comb begin
        ctrl_next = ctrl_reg;
        charge_next = charge_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        prdata_next = prdata;
        pready_next = access && !pready;
        pslverr_next = access && !pready && !addr_hit;
        if (rd_take) begin
            unique case (paddr)
                `BTZM_OFF_CTRL: prdata_next = ctrl_reg;
                `BTZM_OFF_CHARGE: prdata_next = charge_reg;
                `BTZM_OFF_STATUS: prdata_next = {27'h0, state_reg == BTZM_ST_ADJUST,
                                                 state_reg == BTZM_ST_FAULT, zone_reg};
                `BTZM_OFF_IRQ_STAT: prdata_next = {31'h0, irq_stat_reg};
                `BTZM_OFF_IRQ_MASK: prdata_next = {31'h0, irq_mask_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_take) begin
            unique case (paddr)
                `BTZM_OFF_CTRL: ctrl_next = {19'h0, pwdata[12:0]};
                `BTZM_OFF_CHARGE: charge_next = pwdata & 32'h3f3f_3f3f;
                `BTZM_OFF_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata[0];
                `BTZM_OFF_IRQ_MASK: irq_mask_next = pwdata[0];
                default: ctrl_next = ctrl_reg;
            endcase
        end
        // A change in the same cycle as the clear is kept
        if (zone_changed) begin
            irq_stat_next = 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `BTZM_CTRL_RST;
            charge_reg <= `BTZM_CHARGE_RST;
            irq_stat_reg <= 1'b0;
            irq_mask_reg <= `BTZM_MASK_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            ctrl_reg <= ctrl_next;
            charge_reg <= charge_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
        end
    end

    // ----------------------------------------
    // Zone classification
    // ----------------------------------------
    logic enable;
    logic [3:0] mux_sel;
    btzm_zone_t raw_zone;

    assign enable = ctrl_reg[`BTZM_CTRL_EN];
    assign mux_sel = ctrl_reg[`BTZM_CTRL_MUX_LSB +: 4];

    // Channel select is not an input here, so it cannot disturb zones
    btzm_zone_classify u_classify (
        .sense_mv(sense_sync_reg),
        .hot_trip_select(ctrl_reg[`BTZM_CTRL_HOT_LSB +: 2]),
        .warm_trip_select(ctrl_reg[`BTZM_CTRL_WARM_LSB +: 2]),
        .cool_trip_select(ctrl_reg[`BTZM_CTRL_COOL_LSB +: 2]),
        .cold_trip_select(ctrl_reg[`BTZM_CTRL_COLD_LSB +: 2]),
        .zone(raw_zone)
    );

    // Reclassified every enabled cycle; disabled reads as off
    assign zone_next = enable ? raw_zone : BTZM_ZONE_OFF;
    assign zone_changed = clk_en && (zone_next != zone_reg);

    // ----------------------------------------
    // Charger steering state machine
    // ----------------------------------------
    logic [5:0] volt_next, curr_next;
    logic [3:0] saved_next;
    logic strobe_next;

    always_comb begin
        state_next = state_reg;
        unique case (zone_next)
            BTZM_ZONE_OFF: state_next = BTZM_ST_OFF;
            BTZM_ZONE_NORMAL: state_next = BTZM_ST_NORMAL;
            BTZM_ZONE_WARM, BTZM_ZONE_COOL: state_next = BTZM_ST_ADJUST;
            BTZM_ZONE_HOT, BTZM_ZONE_COLD: state_next = BTZM_ST_FAULT;
            default: state_next = BTZM_ST_OFF;
        endcase
        // Zone settings only in the adjusted state
        if (state_next == BTZM_ST_ADJUST) begin
            volt_next = charge_reg[`BTZM_CHG_ZCV_LSB +: 6];
            curr_next = charge_reg[`BTZM_CHG_ZCC_LSB +: 6];
        end else begin
            volt_next = charge_reg[`BTZM_CHG_CV_LSB +: 6];
            curr_next = charge_reg[`BTZM_CHG_CC_LSB +: 6];
        end
        // Charger state captured on entry, held through the fault
        saved_next = resume_state;
        if (state_next == BTZM_ST_FAULT && state_reg != BTZM_ST_FAULT) begin
            saved_next = charger_state;
        end
        strobe_next = (state_reg == BTZM_ST_FAULT) && (state_next != BTZM_ST_FAULT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zone_reg <= BTZM_ZONE_OFF;
            state_reg <= BTZM_ST_OFF;
            applied_charge_voltage <= 6'h00;
            applied_charge_current <= 6'h00;
            zone_adjust_active <= 1'b0;
            temp_fault_active <= 1'b0;
            charger_fault <= 1'b0;
            timers_pause <= 1'b0;
            resume_strobe <= 1'b0;
            resume_state <= 4'h0;
        end else if (clk_en) begin
            zone_reg <= zone_next;
            state_reg <= state_next;
            applied_charge_voltage <= volt_next;
            applied_charge_current <= curr_next;
            zone_adjust_active <= state_next == BTZM_ST_ADJUST;
            temp_fault_active <= state_next == BTZM_ST_FAULT;
            // Any fault stops charging; the temperature flag tells which one wins
            charger_fault <= (state_next == BTZM_ST_FAULT) || other_fault_req;
            timers_pause <= state_next == BTZM_ST_FAULT;
            resume_strobe <= strobe_next;
            resume_state <= saved_next;
        end
    end

    // ----------------------------------------
    // Bias, monitor channel and interrupt
    // ----------------------------------------
    logic bias_next;

    // Bias for the comparators or for an external conversion
    assign bias_next = (valid_sync_reg && enable) ||
                       (mux_sel == `BTZM_MUX_SENSE) || (mux_sel == `BTZM_MUX_BIAS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ntc_bias_source <= 1'b0;
            analog_monitor_out <= 4'h0;
            temperature_change_irq <= 1'b0;
        end else if (clk_en) begin
            ntc_bias_source <= bias_next;
            analog_monitor_out <= mux_sel;
            temperature_change_irq <= irq_stat_next && irq_mask_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fault_entered;
        clk_en && !temp_fault_active ##1 temp_fault_active;
    endsequence

    sequence s_fault_left;
        clk_en && temp_fault_active ##1 !temp_fault_active;
    endsequence

    chk_disabled_no_action: assert property (
        clk_en && !ctrl_next[`BTZM_CTRL_EN] && !wr_take |=> !temp_fault_active && !zone_adjust_active)
        else $error("temperature action while disabled");

    chk_fault_hot_cold: assert property (
        clk_en && (zone_next == BTZM_ZONE_HOT || zone_next == BTZM_ZONE_COLD)
        |=> temp_fault_active && timers_pause)
        else $error("extreme zone without fault pause");

    chk_adjust_values: assert property (
        zone_adjust_active |-> applied_charge_voltage == charge_reg[`BTZM_CHG_ZCV_LSB +: 6]
        || $past(wr_take))
        else $error("adjusted state not using zone voltage");

    chk_normal_values: assert property (
        clk_en && zone_next == BTZM_ZONE_NORMAL |=> !zone_adjust_active && !temp_fault_active
        && applied_charge_current == $past(charge_reg[`BTZM_CHG_CC_LSB +: 6]))
        else $error("normal zone not using normal current");

    chk_fault_resume: assert property (
        s_fault_left |-> resume_strobe && $stable(resume_state))
        else $error("fault exit without resume of saved state");

    chk_fault_capture: assert property (
        s_fault_entered |-> resume_state == $past(charger_state) && charger_fault)
        else $error("fault entry did not save charger state");

    chk_change_irq: assert property (
        zone_changed |=> irq_stat_reg ##0 (temperature_change_irq == irq_mask_reg))
        else $error("zone change did not set interrupt flag");

    chk_bias_drive: assert property (
        clk_en && (mux_sel == `BTZM_MUX_SENSE || mux_sel == `BTZM_MUX_BIAS) |=> ntc_bias_source)
        else $error("bias off while monitor selects thermistor");

    chk_bias_charge: assert property (
        clk_en && valid_sync_reg && enable |=> ntc_bias_source)
        else $error("bias off while charging with monitor enabled");

    chk_apb_answer: assert property (
        clk_en && access && !pready |=> pready ##1 !pready || !clk_en)
        else $error("apb answer not one wait state");

    // Steering, bias, freeze and bus error
    chk_adjust_zone: assert property (
        clk_en && (zone_next == BTZM_ZONE_WARM || zone_next == BTZM_ZONE_COOL)
        |=> zone_adjust_active && !temp_fault_active
        && applied_charge_current == $past(charge_reg[`BTZM_CHG_ZCC_LSB +: 6]))
        else $error("warm or cool zone not using zone settings");

    chk_disabled_zone_off: assert property (
        clk_en && !enable |=> zone_reg == BTZM_ZONE_OFF)
        else $error("zone status not off while disabled");

    chk_fault_priority: assert property (
        temp_fault_active |-> charger_fault && timers_pause)
        else $error("temperature fault not reported as charger fault");

    chk_bias_idle: assert property (
        clk_en && !(valid_sync_reg && enable) && mux_sel != `BTZM_MUX_SENSE
        && mux_sel != `BTZM_MUX_BIAS |=> !ntc_bias_source)
        else $error("bias driven with no reason");

    chk_freeze_state: assert property (
        !clk_en |=> $stable(temp_fault_active) && $stable(zone_reg) && $stable(prdata))
        else $error("state moved while clock enable low");

    chk_apb_unmapped: assert property (
        clk_en && access && !pready && !addr_hit |=> pready && pslverr)
        else $error("unmapped address answered without error");

endmodule
`default_nettype wire

// ### logic/btzm_defs.svh
// Purpose: Constants of the battery temperature zone monitor
// Assumes: Included by bare name from the monitor, the classifier and the testbench
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef BTZM_DEFS_SVH
`define BTZM_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BTZM_OFF_CTRL 8'h00
`define BTZM_OFF_CHARGE 8'h04
`define BTZM_OFF_STATUS 8'h08
`define BTZM_OFF_IRQ_STAT 8'h0c
`define BTZM_OFF_IRQ_MASK 8'h10

// ----------------------------------------
// Control and charge field positions
// ----------------------------------------
`define BTZM_CTRL_EN 0
`define BTZM_CTRL_HOT_LSB 1
`define BTZM_CTRL_WARM_LSB 3
`define BTZM_CTRL_COOL_LSB 5
`define BTZM_CTRL_COLD_LSB 7
`define BTZM_CTRL_MUX_LSB 9
`define BTZM_CHG_CV_LSB 0
`define BTZM_CHG_CC_LSB 8
`define BTZM_CHG_ZCV_LSB 16
`define BTZM_CHG_ZCC_LSB 24

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BTZM_CTRL_RST 32'h0000_0000
`define BTZM_CHARGE_RST 32'h0000_0000
`define BTZM_MASK_RST 1'b0

// ----------------------------------------
// Monitor channel codes that need the bias
// ----------------------------------------
`define BTZM_MUX_SENSE 4'h7
`define BTZM_MUX_BIAS 4'h8

// ----------------------------------------
// Trip voltages in millivolts, code 0..3
// ----------------------------------------
`define BTZM_MV_1024 11'h400
`define BTZM_MV_0976 11'h3d0
`define BTZM_MV_0923 11'h39b
`define BTZM_MV_0867 11'h363
`define BTZM_MV_0807 11'h327
`define BTZM_MV_0747 11'h2eb
`define BTZM_MV_0511 11'h1ff
`define BTZM_MV_0459 11'h1cb
`define BTZM_MV_0411 11'h19b
`define BTZM_MV_0367 11'h16f
`define BTZM_MV_0327 11'h147
`define BTZM_MV_0291 11'h123

`endif

// ### logic/btzm_pkg.sv
// Purpose: Types of the battery temperature zone monitor
// Assumes: Constants live in btzm_defs.svh
// Notes:   Zone codes are what software reads in the status field
package btzm_pkg;

    // ----------------------------------------
    // Zone status codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        BTZM_ZONE_OFF = 3'h0,
        BTZM_ZONE_COLD = 3'h1,
        BTZM_ZONE_COOL = 3'h2,
        BTZM_ZONE_NORMAL = 3'h3,
        BTZM_ZONE_WARM = 3'h4,
        BTZM_ZONE_HOT = 3'h5
    } btzm_zone_t;

    // ----------------------------------------
    // Charger steering states, one-hot
    // ----------------------------------------
    typedef enum logic [3:0] {
        BTZM_ST_OFF = 4'h1,
        BTZM_ST_NORMAL = 4'h2,
        BTZM_ST_ADJUST = 4'h4,
        BTZM_ST_FAULT = 4'h8
    } btzm_state_t;

    typedef enum logic [1:0] {
        BTZM_KIND_HOT = 2'h0,
        BTZM_KIND_WARM = 2'h1,
        BTZM_KIND_COOL = 2'h2,
        BTZM_KIND_COLD = 2'h3
    } btzm_kind_t;

endpackage

// ### logic/btzm_zone_classify.sv
// Purpose: Turns a sensed voltage and four trip selects into a zone
// Assumes: Sense value is already synchronised, in millivolts
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
`include "btzm_defs.svh"

module btzm_zone_classify (
    // Sensed level
    input wire logic [10:0] sense_mv,
    // Trip selects
    input wire logic [1:0] hot_trip_select,
    input wire logic [1:0] warm_trip_select,
    input wire logic [1:0] cool_trip_select,
    input wire logic [1:0] cold_trip_select,
    // Result
    output btzm_pkg::btzm_zone_t zone
);
    import btzm_pkg::*;

    // ----------------------------------------
    // Trip level lookup
    // ----------------------------------------
    // Each kind spans four adjacent levels, code 0 the highest voltage
    function automatic logic [10:0] trip_mv(input btzm_kind_t kind, input logic [1:0] sel);
        logic [10:0] lv;
        lv = `BTZM_MV_0291;
        unique case (kind)
            BTZM_KIND_COLD: begin
                lv = (sel == 2'h0) ? `BTZM_MV_1024 : (sel == 2'h1) ? `BTZM_MV_0976 :
                     (sel == 2'h2) ? `BTZM_MV_0923 : `BTZM_MV_0867;
            end
            BTZM_KIND_COOL: begin
                lv = (sel == 2'h0) ? `BTZM_MV_0923 : (sel == 2'h1) ? `BTZM_MV_0867 :
                     (sel == 2'h2) ? `BTZM_MV_0807 : `BTZM_MV_0747;
            end
            BTZM_KIND_WARM: begin
                lv = (sel == 2'h0) ? `BTZM_MV_0511 : (sel == 2'h1) ? `BTZM_MV_0459 :
                     (sel == 2'h2) ? `BTZM_MV_0411 : `BTZM_MV_0367;
            end
            BTZM_KIND_HOT: begin
                lv = (sel == 2'h0) ? `BTZM_MV_0411 : (sel == 2'h1) ? `BTZM_MV_0367 :
                     (sel == 2'h2) ? `BTZM_MV_0327 : `BTZM_MV_0291;
            end
        endcase
        return lv;
    endfunction

    // ----------------------------------------
    // Comparators
    // ----------------------------------------
    // Low voltage means hot on an NTC divider; extremes checked first
    always_comb begin
        if (sense_mv < trip_mv(BTZM_KIND_HOT, hot_trip_select)) begin
            zone = BTZM_ZONE_HOT;
        end else if (sense_mv > trip_mv(BTZM_KIND_COLD, cold_trip_select)) begin
            zone = BTZM_ZONE_COLD;
        end else if (sense_mv < trip_mv(BTZM_KIND_WARM, warm_trip_select)) begin
            zone = BTZM_ZONE_WARM;
        end else if (sense_mv > trip_mv(BTZM_KIND_COOL, cool_trip_select)) begin
            zone = BTZM_ZONE_COOL;
        end else begin
            zone = BTZM_ZONE_NORMAL;
        end
    end

endmodule
`default_nettype wire

// ### sim/btzm_charger_model.sv
// Purpose: Charger state machine seen from the zone monitor
// Assumes: One-hot charger states, same clock as the monitor
// Notes:   Timer stalls in fault; resume reloads the held state
`timescale 1ns/100ps
`default_nettype none

module btzm_charger_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // From the monitor
    input wire logic timers_pause,
    input wire logic resume_strobe,
    input wire logic [3:0] resume_state,
    // To the monitor
    output logic [3:0] charger_state
);
    logic [3:0] state_reg, state_next, tick_reg, tick_next;

    // Step every 16 cycles; a resume restarts the tick so the
    // restored state is held long enough to be compared
    always_comb begin
        state_next = state_reg;
        tick_next = tick_reg + 4'h1;
        if (resume_strobe) begin
            state_next = resume_state;
            tick_next = 4'h0;
        end else if (timers_pause) begin
            tick_next = tick_reg;
        end else if (tick_reg == 4'hf) begin
            state_next = {state_reg[2:0], state_reg[3]};
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= 4'h1;
            tick_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            tick_reg <= tick_next;
        end
    end
    assign charger_state = state_reg;
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Purpose: Self-checking bench for the zone monitor
// Assumes: APB slave answers in bounded time; sense in mV
// Notes:   Trip codes hot 3, warm 1, cool 2, cold 1 in zone tests
`timescale 1ns/100ps
`default_nettype none
`include "btzm_defs.svh"

module testbench;
    import btzm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, valid, ofault;
    logic adj, flt, cfault, tpause, rstb, bias, irq, rde, ce;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdq, es;
    logic [10:0] sense;
    logic [5:0] cv, cc;
    logic [3:0] cstate, rstate, mux;
    int errors, n_checks, i, n_res;
    logic [10:0] sv [9] = '{11'h258, 11'h1cb, 11'h1ca, 11'h12c, 11'h122,
        11'h327, 11'h328, 11'h3d0, 11'h3d1};
    btzm_zone_t zv [9] = '{BTZM_ZONE_NORMAL, BTZM_ZONE_NORMAL, BTZM_ZONE_WARM,
        BTZM_ZONE_WARM, BTZM_ZONE_HOT, BTZM_ZONE_NORMAL, BTZM_ZONE_COOL,
        BTZM_ZONE_COOL, BTZM_ZONE_COLD};

    // ----------------------------------------
    // Design and charger model
    // ----------------------------------------
    btzm_monitor u_btzm_monitor (.pclk(pclk), .presetn(presetn), .clk_en(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ntc_sense_pin(sense), .charge_input_valid(valid), .charger_state(cstate),
        .other_fault_req(ofault), .applied_charge_voltage(cv),
        .applied_charge_current(cc), .zone_adjust_active(adj),
        .temp_fault_active(flt), .charger_fault(cfault), .timers_pause(tpause),
        .resume_strobe(rstb), .resume_state(rstate), .ntc_bias_source(bias),
        .analog_monitor_out(mux), .temperature_change_irq(irq));
    btzm_charger_model u_btzm_charger_model (.pclk(pclk), .presetn(presetn),
        .timers_pause(tpause), .resume_strobe(rstb), .resume_state(rstate),
        .charger_state(cstate));

    // ----------------------------------------
    // Clock, watchdog and tasks
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Resume pulses stand one cycle; count them at the edge
    always @(posedge pclk) begin
        if (rstb === 1'b1) n_res++;
    end
    // A hung handshake must still end the run with a verdict
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        test_done();
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle edge first, so a release never meets a new setup
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdq = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdq, exp);
    endtask
    task pin(input logic [10:0] v);
        @(posedge pclk);
        sense <= v;
        repeat (5) @(posedge pclk);
    endtask
    task end_test(input string s);
        $display("test %s done", s);
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ofault} = '0;
        ce = 1'b1;
        sense = 11'h258;
        valid = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`BTZM_OFF_CTRL, 32'h0);
        rd(`BTZM_OFF_CHARGE, 32'h0);
        rd(`BTZM_OFF_IRQ_MASK, 32'h0);
        rd(`BTZM_OFF_STATUS, 32'h0);
        rd(8'h14, 32'h0);
        chk({31'h0, rde}, 32'h1);
        end_test("reset");
        apb(1'b1, `BTZM_OFF_CHARGE, 32'h0605_2211);
        rd(`BTZM_OFF_CHARGE, 32'h0605_2211);
        apb(1'b1, `BTZM_OFF_CTRL, 32'h0000_00cf);
        rd(`BTZM_OFF_CTRL, 32'h0000_00cf);
        for (i = 0; i < 9; i++) begin
            pin(sv[i]);
            es = {27'h0, zv[i] == BTZM_ZONE_WARM || zv[i] == BTZM_ZONE_COOL,
                zv[i] == BTZM_ZONE_HOT || zv[i] == BTZM_ZONE_COLD, zv[i]};
            chk({26'h0, cv}, es[4] ? 32'h5 : 32'h11);
            chk({26'h0, cc}, es[4] ? 32'h6 : 32'h22);
            chk({31'h0, adj}, {31'h0, es[4]});
            chk({31'h0, cfault}, {31'h0, es[3]});
            chk({31'h0, flt}, {31'h0, es[3]});
            chk({31'h0, tpause}, {31'h0, es[3]});
            chk({31'h0, bias}, 32'h1);
            if (i == 5) chk({28'h0, cstate}, {28'h0, rstate});
            rd(`BTZM_OFF_STATUS, es);
        end
        chk(n_res, 32'h1);
        end_test("zones");
        ofault <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({30'h0, flt, cfault}, 32'h3);
        ofault <= 1'b0;
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `BTZM_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `BTZM_OFF_IRQ_STAT, 32'h1);
        rd(`BTZM_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        ofault <= 1'b1;
        pin(11'h1ca);
        chk({30'h0, flt, cfault}, 32'h1);
        ofault <= 1'b0;
        chk({31'h0, irq}, 32'h1);
        end_test("irq");
        apb(1'b1, `BTZM_OFF_CTRL, 32'h0);
        repeat (4) @(posedge pclk);
        rd(`BTZM_OFF_STATUS, 32'h0);
        chk({30'h0, adj, bias}, 32'h0);
        chk({26'h0, cv}, 32'h11);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, `BTZM_OFF_CTRL, {19'h0, (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : 4'h2,
                9'h0});
            repeat (3) @(posedge pclk);
            chk({31'h0, bias}, {31'h0, i != 2});
        end
        apb(1'b1, `BTZM_OFF_CTRL, 32'h0000_0ecf);
        pin(11'h122);
        rd(`BTZM_OFF_STATUS, 32'h0000_000d);
        chk({28'h0, mux}, 32'h7);
        apb(1'b1, `BTZM_OFF_CTRL, 32'h0000_00cf);
        valid <= 1'b0;
        repeat (5) @(posedge pclk);
        chk({31'h0, bias}, 32'h0);
        end_test("bias");
        ce <= 1'b0;
        pin(11'h258);
        chk({31'h0, flt}, 32'h1);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({31'h0, flt}, 32'h0);
        end_test("freeze");
        test_done();
    end
endmodule
`default_nettype wire
